/* File: verilog/remap_input_pkg.sv */
// Constants for the remappable peripheral input selection block
package remap_input_pkg;

  // Bus widths
  localparam int ADDR_W     = 12;
  localparam int DATA_W     = 32;
  localparam int FLD_W      = 5;
  localparam int NUM_PINS   = 16;
  localparam int NUM_FIELDS = 14;

  // Byte addresses of the input selection registers
  localparam logic [11:0] OFS_SEL_IRQ1  = 12'h000;
  localparam logic [11:0] OFS_SEL_IRQ2  = 12'h004;
  localparam logic [11:0] OFS_SEL_TMR   = 12'h00C;
  localparam logic [11:0] OFS_SEL_CAP12 = 12'h01C;
  localparam logic [11:0] OFS_SEL_CAP78 = 12'h028;
  localparam logic [11:0] OFS_SEL_FAULT = 12'h02C;
  localparam logic [11:0] OFS_SEL_UART  = 12'h048;
  localparam logic [11:0] OFS_SEL_SPI   = 12'h050;
  localparam logic [11:0] OFS_SEL_SS    = 12'h054;
  // Oscillator control register, holds the lock bit
  localparam logic [11:0] OFS_OSC_CTRL  = 12'h080;

  // Field order: irq1, irq2, t3clk, t2clk, cap2, cap1, cap8, cap7,
  // fault A, uart cts, uart rx, spi clock, spi data, spi slave select
  localparam logic [11:0] FIELD_OFS [NUM_FIELDS] = '{
    OFS_SEL_IRQ1, OFS_SEL_IRQ2, OFS_SEL_TMR, OFS_SEL_TMR,
    OFS_SEL_CAP12, OFS_SEL_CAP12, OFS_SEL_CAP78, OFS_SEL_CAP78,
    OFS_SEL_FAULT, OFS_SEL_UART, OFS_SEL_UART, OFS_SEL_SPI,
    OFS_SEL_SPI, OFS_SEL_SS};
  // One when the field sits in bits 12..8, zero for bits 4..0
  localparam logic FIELD_HI [NUM_FIELDS] = '{
    1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0,
    1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

  // Field values
  localparam logic [4:0] FLD_RESET = 5'h1F;
  localparam int         FLD_GND_BIT = 4;

  // Lock control
  localparam int         LOCK_BIT = 6;
  localparam logic [7:0] KEY_FIRST  = 8'h46;
  localparam logic [7:0] KEY_SECOND = 8'h57;

  // Unlock sequence states
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_GOT_FIRST, SEQ_ARMED} seq_state_t;

endpackage

/* File: verilog/remappable_input_select.sv */
// Remappable peripheral input selection with APB register access
//
// Notes on behaviour
// - Seventeen remap registers; nine input ones here.
// - Selection registers change only while unlocked.
// - Five-bit fields; all ones ties to ground.
// - Codes 0 to 15 pick that pin.
// - Unimplemented bits read zero, ignore writes.
// - Register 0 bits 12..8: interrupt 1.
// - Register 1 bits 4..0: interrupt 2.
// - Register 3: timer 3 high, timer 2 low.
// - Register 7: capture 2 high, capture 1 low.
// - Register 10: capture 8 high, capture 7 low.
// - Register 11 bits 4..0: compare fault A.
// - Register 18: UART CTS high, RX low.
// - Register 20: SPI clock high, data low.
// - Register 21 bits 4..0: SPI slave select.
// - Locked writes complete without error, no change.
// - Shadow compare raises a mismatch reset request.
// - One-way option forbids clearing lock again.
`timescale 1ns/10ps

module remappable_input_select
  import remap_input_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_srst,
  // APB slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [DATA_W-1:0] i_pwdata,
  input  wire logic [3:0]        i_pstrb,
  output logic      [DATA_W-1:0] o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // Configuration option and pins
  input  wire logic              i_one_way_lock_option,
  input  wire logic [NUM_PINS-1:0] i_remappable_pin,
  // Peripheral inputs
  output logic                   o_ext_irq1,
  output logic                   o_ext_irq2,
  output logic                   o_timer3_clock,
  output logic                   o_timer2_clock,
  output logic                   o_capture2,
  output logic                   o_capture1,
  output logic                   o_capture8,
  output logic                   o_capture7,
  output logic                   o_compare_fault_a_input,
  output logic                   o_uart_cts,
  output logic                   o_uart_rx,
  output logic                   o_spi_clock_input,
  output logic                   o_spi_data_in,
  output logic                   o_spi_slave_sel_input,
  // Status
  output logic                   o_pin_select_lock,
  output logic                   o_config_mismatch_reset
);

  // Field storage and its shadow copy
  logic [FLD_W-1:0]      fld_r   [NUM_FIELDS];
  logic [FLD_W-1:0]      shd_r   [NUM_FIELDS];
  // Per-field decode and read contributions
  logic [NUM_FIELDS-1:0] fld_hit;
  logic [NUM_FIELDS-1:0] fld_we;
  logic [NUM_FIELDS-1:0] fld_diff;
  logic [DATA_W-1:0]     fld_rd  [NUM_FIELDS];
  logic [FLD_W-1:0]      fld_wd  [NUM_FIELDS];
  // Routed peripheral inputs
  logic [NUM_FIELDS-1:0] route;
  logic [NUM_FIELDS-1:0] periph_r;
  // Bus handshake
  logic                  pready_r;
  logic                  pready_nxt;
  logic [DATA_W-1:0]     prdata_r;
  logic                  pslverr_r;
  // Lock state
  logic                  lock_r;
  logic                  lock_nxt;
  logic                  lock_once_r;
  seq_state_t            seq_r;
  seq_state_t            seq_nxt;
  logic                  mismatch_r;

  // Bus decode
  wire        osc_hit   = (i_paddr == OFS_OSC_CTRL);
  wire        any_hit   = (|fld_hit) | osc_hit;
  wire        acc_done  = i_psel & i_penable & pready_r;
  wire        bus_wr    = acc_done & i_pwrite;
  wire        osc_wr    = bus_wr & osc_hit & i_pstrb[0];
  wire        other_wr  = bus_wr & ~osc_wr;
  wire [7:0]  wr_byte   = i_pwdata[7:0];
  wire        sel_wr_ok = bus_wr & ~lock_r;
  wire        lock_req  = i_pwdata[LOCK_BIT];
  wire        clr_ok    = ~(i_one_way_lock_option & lock_once_r);
  wire [DATA_W-1:0] osc_rd = {25'h0000000, lock_r, 6'h00};

  // Answer one cycle into the access phase
  assign pready_nxt = i_psel & i_penable & ~pready_r;

  // Per-field decode, write data, read data and routing
  genvar g;
  generate
    for (g = 0; g < NUM_FIELDS; g++) begin : g_field
      // Address match for the register holding this field
      assign fld_hit[g] = (i_paddr == FIELD_OFS[g]);
      // Field position inside the word
      assign fld_wd[g]  = FIELD_HI[g] ? i_pwdata[12:8] : i_pwdata[4:0];
      // Byte lane of the field must be enabled
      assign fld_we[g]  = sel_wr_ok & fld_hit[g] &
                          (FIELD_HI[g] ? i_pstrb[1] : i_pstrb[0]);
      // Other bits of the word read as zero
      assign fld_rd[g]  = !fld_hit[g] ? 32'h00000000 :
                          FIELD_HI[g] ? {19'h00000, fld_r[g], 8'h00}
                                      : {27'h0000000, fld_r[g]};
      // Codes with the top bit set tie the input low
      assign route[g]   = fld_r[g][FLD_GND_BIT] ? 1'b0
                          : i_remappable_pin[fld_r[g][3:0]];
      // Live copy differs from its shadow
      assign fld_diff[g] = (fld_r[g] != shd_r[g]);

      // Field and shadow store
      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          fld_r[g] <= FLD_RESET;
          shd_r[g] <= FLD_RESET;
        end else if (fld_we[g]) begin
          fld_r[g] <= fld_wd[g];
          shd_r[g] <= fld_wd[g];
        end
      end
    end
  endgenerate

  // Read data: OR of all field words and the lock register
  logic [DATA_W-1:0] rd_word;
  always_comb begin
    rd_word = osc_hit ? osc_rd : 32'h00000000;
    for (int i = 0; i < NUM_FIELDS; i++) begin
      rd_word = rd_word | fld_rd[i];
    end
  end

  // Unlock key sequence on the low byte of the oscillator register
  always_comb begin
    seq_nxt  = seq_r;
    lock_nxt = lock_r;
    unique case (seq_r)
      SEQ_IDLE: begin
        if (osc_wr && wr_byte == KEY_FIRST) begin
          seq_nxt = SEQ_GOT_FIRST;
        end
      end
      SEQ_GOT_FIRST: begin
        if (osc_wr) begin
          // Second key arms, a repeated first key restarts
          if (wr_byte == KEY_SECOND) begin
            seq_nxt = SEQ_ARMED;
          end else if (wr_byte == KEY_FIRST) begin
            seq_nxt = SEQ_GOT_FIRST;
          end else begin
            seq_nxt = SEQ_IDLE;
          end
        end else if (other_wr) begin
          seq_nxt = SEQ_IDLE;
        end
      end
      SEQ_ARMED: begin
        if (osc_wr) begin
          // One write sets or clears the lock
          seq_nxt = SEQ_IDLE;
          if (lock_req) begin
            lock_nxt = 1'b1;
          end else if (clr_ok) begin
            lock_nxt = 1'b0;
          end
        end else if (other_wr) begin
          seq_nxt = SEQ_IDLE;
        end
      end
    endcase
  end

  // Lock and sequence registers
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      seq_r       <= SEQ_IDLE;
      lock_r      <= 1'b0;
      lock_once_r <= 1'b0;
    end else begin
      seq_r       <= seq_nxt;
      lock_r      <= lock_nxt;
      lock_once_r <= lock_once_r | lock_nxt;
    end
  end

  // APB answer registers
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= pready_nxt;
      // Locked writes still answer without error
      // Only the nine input selection words and the lock word are mapped
      pslverr_r <= pready_nxt & ~any_hit;
      prdata_r  <= (pready_nxt & ~i_pwrite) ? rd_word : 32'h00000000;
    end
  end

  // Routed inputs and mismatch request
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      periph_r   <= '0;
      mismatch_r <= 1'b0;
    end else begin
      periph_r   <= route;
      mismatch_r <= |fld_diff;
    end
  end

  // Bus outputs
  assign o_prdata  = prdata_r;
  assign o_pready  = pready_r;
  assign o_pslverr = pslverr_r;

  // Peripheral outputs in field order
  assign o_ext_irq1              = periph_r[0];
  assign o_ext_irq2              = periph_r[1];
  assign o_timer3_clock          = periph_r[2];
  assign o_timer2_clock          = periph_r[3];
  assign o_capture2              = periph_r[4];
  assign o_capture1              = periph_r[5];
  assign o_capture8              = periph_r[6];
  assign o_capture7              = periph_r[7];
  assign o_compare_fault_a_input = periph_r[8];
  assign o_uart_cts              = periph_r[9];
  assign o_uart_rx               = periph_r[10];
  assign o_spi_clock_input       = periph_r[11];
  assign o_spi_data_in           = periph_r[12];
  assign o_spi_slave_sel_input   = periph_r[13];

  // Status outputs
  assign o_pin_select_lock       = lock_r;
  assign o_config_mismatch_reset = mismatch_r;

endmodule

/* File: sim/remappable_input_select_properties.sv */
// Checker of bus timing, read data and lock behaviour
`timescale 1ns/10ps
module remappable_input_select_properties (
  // Clock, reset and bus
  input wire logic        i_clk,
  input wire logic        i_srst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  // Lock option and status
  input wire logic        i_one_way_lock_option,
  input wire logic        o_pin_select_lock,
  input wire logic        o_config_mismatch_reset
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // One wait cycle, then the answer
  a_ready_one_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("pready missing after one wait");
  a_ready_in_access: assert property (o_pready |-> i_psel && i_penable && $past(i_penable))
    else $error("pready outside access phase");
  a_ready_single: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  // Error only with the answer, and no data with it
  a_err_no_data: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
    else $error("slave error without pready or with data");
  a_idle_data_zero: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside answer");
  a_upper_bits_zero: assert property (o_pready |-> o_prdata[31:13] == 19'h0)
    else $error("unimplemented bits read nonzero");
  // Lock moves only through a write to the control register
  a_lock_by_write: assert property ($changed(o_pin_select_lock) |->
    $past(i_srst) || $past(o_pready && i_pwrite && i_paddr == 12'h080))
    else $error("lock changed without a write");
  a_one_way_hold: assert property (i_one_way_lock_option && o_pin_select_lock |=> o_pin_select_lock)
    else $error("one way lock cleared");
  a_no_mismatch: assert property (!o_config_mismatch_reset)
    else $error("mismatch reset without fault");
endmodule

bind remappable_input_select remappable_input_select_properties u_props (
  .i_clk(i_clk), .i_srst(i_srst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_one_way_lock_option(i_one_way_lock_option),
  .o_pin_select_lock(o_pin_select_lock), .o_config_mismatch_reset(o_config_mismatch_reset));

/* File: sim/remappable_input_select_test.sv */
// Self-checking bench for the remappable input selection block
`timescale 1ns/10ps
module remappable_input_select_test;
  import remap_input_pkg::*;
  // Bench drives and observed outputs
  logic        i_clk, i_srst, i_psel, i_penable, i_pwrite, i_opt, er;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic [3:0]  i_pstrb;
  logic [15:0] i_pin;
  logic [13:0] rt;
  logic        o_pready, o_pslverr, o_lock, o_mis;
  int          num_errors, checks;
  // Register addresses and their reset values, equal to the implemented bits
  logic [11:0] ra [9] = '{12'h000, 12'h004, 12'h00C, 12'h01C, 12'h028, 12'h02C,
                          12'h048, 12'h050, 12'h054};
  logic [15:0] rv [9] = '{16'h1F00, 16'h001F, 16'h1F1F, 16'h1F1F, 16'h1F1F,
                          16'h001F, 16'h1F1F, 16'h1F1F, 16'h001F};

  remappable_input_select DUT (
    .i_clk(i_clk), .i_srst(i_srst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_one_way_lock_option(i_opt), .i_remappable_pin(i_pin),
    .o_ext_irq1(rt[13]), .o_ext_irq2(rt[12]), .o_timer3_clock(rt[11]),
    .o_timer2_clock(rt[10]), .o_capture2(rt[9]), .o_capture1(rt[8]),
    .o_capture8(rt[7]), .o_capture7(rt[6]), .o_compare_fault_a_input(rt[5]),
    .o_uart_cts(rt[4]), .o_uart_rx(rt[3]), .o_spi_clock_input(rt[2]),
    .o_spi_data_in(rt[1]), .o_spi_slave_sel_input(rt[0]),
    .o_pin_select_lock(o_lock), .o_config_mismatch_reset(o_mis));

  // Clock of 40 ns
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    i_pstrb <= s;
    @(posedge i_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (o_pready !== 1'b1) num_errors++;
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask

  // Key sequence then lock value
  task automatic lk(input logic [7:0] v);
    xf(1'b1, 12'h080, 32'h46, 4'h1);
    xf(1'b1, 12'h080, 32'h57, 4'h1);
    xf(1'b1, 12'h080, {24'h0, v}, 4'h1);
  endtask

  // Let routed outputs follow
  task automatic st;
    repeat (3) @(posedge i_clk);
  endtask

  // Reset values, grounded outputs, implemented bits, unmapped access
  task automatic t_regs;
    st();
    chk("grounded outputs", rt, 14'h0);
    for (int k = 0; k < 9; k++) begin
      xf(1'b0, ra[k], 32'h0, 4'h0);
      chk("reset value", rd, {16'h0, rv[k]});
      xf(1'b1, ra[k], 32'hFFFFFFFF, 4'hF);
      xf(1'b0, ra[k], 32'h0, 4'h0);
      chk("implemented bits", rd, {16'h0, rv[k]});
    end
    xf(1'b0, 12'h008, 32'h0, 4'h0);
    chk("unmapped error", er, 1'b1);
    $display("test regs done");
  endtask

  // Every field to its own pin through single lane writes
  task automatic t_map;
    logic [13:0] e;
    for (int f = 0; f < NUM_FIELDS; f++)
      xf(1'b1, FIELD_OFS[f], FIELD_HI[f] ? 32'(f) << 8 : 32'(f), FIELD_HI[f] ? 4'h2 : 4'h1);
    for (int p = 0; p < 2; p++) begin
      i_pin <= p ? 16'h1C96 : 16'h2A5B;
      st();
      for (int f = 0; f < NUM_FIELDS; f++) e[13 - f] = i_pin[f];
      chk("routed pins", rt, e);
    end
    $display("test map done");
  endtask

  // All 32 codes on the receive field
  task automatic t_codes;
    for (int c = 0; c < 32; c++) begin
      xf(1'b1, 12'h048, 32'(c), 4'h1);
      i_pin <= c < 16 ? 16'h1 << c : 16'hFFFF;
      st();
      chk("code selects pin", rt[3], c < 16);
      i_pin <= ~(16'h1 << c[3:0]);
      st();
      chk("code ignores others", rt[3], 1'b0);
    end
    $display("test codes done");
  endtask

  // Lock, locked writes, keyless change, one way option
  task automatic t_lock;
    logic [31:0] old;
    lk(8'h40);
    chk("lock set", o_lock, 1'b1);
    xf(1'b0, 12'h080, 32'h0, 4'h0);
    chk("lock read", rd, 32'h40);
    xf(1'b0, 12'h048, 32'h0, 4'h0);
    old = rd;
    xf(1'b1, 12'h048, 32'h0305, 4'h3);
    chk("locked write error", er, 1'b0);
    xf(1'b0, 12'h048, 32'h0, 4'h0);
    chk("locked field", rd, old);
    xf(1'b1, 12'h080, 32'h0, 4'h1);
    chk("keyless clear", o_lock, 1'b1);
    lk(8'h00);
    chk("lock cleared", o_lock, 1'b0);
    i_opt <= 1'b1;
    lk(8'h40);
    lk(8'h00);
    chk("one way lock", o_lock, 1'b1);
    chk("mismatch", o_mis, 1'b0);
    $display("test lock done");
  endtask

  // Counts and verdict
  task automatic wrap_up;
    $display("%0d checks, %0d mismatches", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    {i_psel, i_penable, i_pwrite, i_opt, i_paddr, i_pwdata, i_pstrb} = '0;
    i_srst = 1'b1;
    i_pin = 16'hFFFF;
    repeat (20) @(posedge i_clk);
    i_srst <= 1'b0;
    t_regs();
    t_map();
    t_codes();
    t_lock();
    wrap_up();
  end

  // Watchdog against a hang
  initial begin
    #400000;
    num_errors++;
    wrap_up();
  end
endmodule
